// ---- ctb_bit_timing.sv ----
// bit-timing configuration registers and bit segment engine
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module ctb_bit_timing (
   input  wire logic        clk_in,              // module clock, 200 MHz
   input  wire logic        reset_in,            // async reset, high
   input  wire logic [3:0]  avs_address_in,      // byte address
   input  wire logic        avs_read_in,         // read request
   input  wire logic        avs_write_in,        // write request
   input  wire logic [31:0] avs_writedata_in,    // write data
   input  wire logic [3:0]  avs_byteenable_in,   // byte lanes
   output logic [31:0]      avs_readdata_out,    // read data
   output logic             avs_waitrequest_out, // stall
   input  wire logic        bus_rx_in,           // bus line, 1 = recessive
   output logic             tq_tick_out,         // quantum tick
   output logic             bit_start_out,       // bit begins
   output logic             sample_point_out,    // sample taken
   output logic             sampled_bit_out,     // last sampled bit
   output logic [1:0]       segment_out,         // current segment
   output logic             wake_event_out       // wake-up detect
);
   logic [15:0] pj_reg_ff;
   logic [15:0] seg_reg_ff;
   logic        tq_tick;
   ctb_pkg::ctb_seg_e state_ff, nxt_state;
   logic [3:0]  seg_cnt_ff, nxt_cnt;
   logic [3:0]  ph1_act_ff, nxt_ph1;
   logic [3:0]  ph2_act_ff, nxt_ph2;
   logic        resynced_ff, nxt_resynced;
   logic        sp_hit, bit_begin, early_end;
   logic        rx_prev_ff;
   logic [1:0]  hist_ff;
   logic        last_bit_ff;
   logic [4:0]  low_run_ff;
   logic        cfg_dirty_ff;
   logic [31:0] rd_mux;
   logic [3:0]  prop_len, ph1_len, ph2_prog, ph2_eff, sjw_len, ph2_left, ext;
   logic [4:0]  err;
   logic        fall, resync_ok, wr_ack, vote_on, wake_sel;

   ctb_quantum_div u_div (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .prescale_in (pj_reg_ff[ctb_pkg::PRESCALE_LSB +: 6]),
      .tick_out    (tq_tick)
   );

   assign tq_tick_out = tq_tick;
   assign segment_out = 2'(state_ff);
   assign sampled_bit_out = last_bit_ff;

   assign sjw_len  = 4'({2'b00, pj_reg_ff[ctb_pkg::JUMP_LSB +: 2]} + 4'h1);
   assign prop_len = ctb_pkg::ctb_len(seg_reg_ff[ctb_pkg::PROP_LSB +: 3]);
   assign ph1_len  = ctb_pkg::ctb_len(seg_reg_ff[ctb_pkg::PH1_LSB +: 3]);
   assign ph2_prog = ctb_pkg::ctb_len(seg_reg_ff[ctb_pkg::PH2_LSB +: 3]);
   assign ph2_eff  = seg_reg_ff[ctb_pkg::POLICY_BIT] ? ph2_prog :
                     ((ph1_len > ctb_pkg::IPT_TQ) ? ph1_len : ctb_pkg::IPT_TQ);
   assign vote_on  = seg_reg_ff[ctb_pkg::VOTE_BIT];
   assign wake_sel = seg_reg_ff[ctb_pkg::WAKE_BIT];

   // ---------------- register bus slave
   assign wr_ack = ~avs_waitrequest_out & avs_write_in;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_in)
         ctb_pkg::OFS_PRESCALE_JUMP: rd_mux = {16'h0000, pj_reg_ff};
         ctb_pkg::OFS_SEGMENTS:      rd_mux = {16'h0000, seg_reg_ff};
         ctb_pkg::OFS_STATUS: begin
            rd_mux[ctb_pkg::ST_BIT]          = last_bit_ff;
            rd_mux[ctb_pkg::ST_SEG_LSB +: 2] = 2'(state_ff);
            rd_mux[ctb_pkg::ST_RESYNC]       = resynced_ff;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // one wait cycle per access; the write lands on the edge that ends the following waitrequest-low cycle
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
      end else if (!avs_waitrequest_out) begin
         avs_waitrequest_out <= 1'b1;
      end else if (avs_read_in || avs_write_in) begin
         avs_waitrequest_out <= 1'b0;
         avs_readdata_out    <= avs_read_in ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pj_reg_ff  <= ctb_pkg::RST_PRESCALE_JUMP;
         seg_reg_ff <= ctb_pkg::RST_SEGMENTS;
      end else if (wr_ack) begin
         if (avs_address_in == ctb_pkg::OFS_PRESCALE_JUMP) begin
            pj_reg_ff <= ctb_pkg::ctb_merge(pj_reg_ff, avs_writedata_in[15:0],
                                            avs_byteenable_in[1:0]) & ctb_pkg::MASK_PRESCALE_JUMP;
         end
         if (avs_address_in == ctb_pkg::OFS_SEGMENTS) begin
            seg_reg_ff <= ctb_pkg::ctb_merge(seg_reg_ff, avs_writedata_in[15:0],
                                             avs_byteenable_in[1:0]) & ctb_pkg::MASK_SEGMENTS;
         end
      end
   end

   // ---------------- segment engine
   assign fall      = rx_prev_ff & ~bus_rx_in;
   // only one resync per bit, and only on a recessive-to-dominant edge
   assign resync_ok = fall & last_bit_ff & ~resynced_ff;
   assign err       = (state_ff == ctb_pkg::SEG_PH1) ?
                      5'({1'b0, prop_len} + {1'b0, seg_cnt_ff} + 5'h01) :
                      5'({1'b0, seg_cnt_ff} + 5'h01);
   assign ext       = (err > {1'b0, sjw_len}) ? sjw_len : err[3:0];
   assign ph2_left  = 4'(ph2_act_ff - seg_cnt_ff);

   always_comb begin
      nxt_state    = state_ff;
      nxt_cnt      = seg_cnt_ff;
      nxt_ph1      = ph1_act_ff;
      nxt_ph2      = ph2_act_ff;
      nxt_resynced = resynced_ff;
      sp_hit       = 1'b0;
      bit_begin    = 1'b0;
      early_end    = 1'b0;
      if (resync_ok) begin
         unique case (state_ff)
            ctb_pkg::SEG_SYNC: nxt_resynced = resynced_ff;
            ctb_pkg::SEG_PROP,
            ctb_pkg::SEG_PH1: begin
               nxt_ph1      = 4'(ph1_act_ff + ext);
               nxt_resynced = 1'b1;
            end
            ctb_pkg::SEG_PH2: begin
               nxt_resynced = 1'b1;
               if (ph2_left <= sjw_len) begin
                  early_end = 1'b1;
               end else begin
                  nxt_ph2 = 4'(ph2_act_ff - sjw_len);
               end
            end
         endcase
      end
      if (early_end) begin
         nxt_state = ctb_pkg::SEG_SYNC;
         nxt_cnt   = 4'h0;
      end else if (tq_tick) begin
         unique case (state_ff)
            ctb_pkg::SEG_SYNC: begin
               nxt_state    = ctb_pkg::SEG_PROP;
               nxt_cnt      = 4'h0;
               nxt_ph1      = ph1_len;
               nxt_ph2      = ph2_eff;
               nxt_resynced = 1'b0;
               bit_begin    = 1'b1;
            end
            ctb_pkg::SEG_PROP: begin
               if (4'(seg_cnt_ff + 4'h1) >= prop_len) begin
                  nxt_state = ctb_pkg::SEG_PH1;
                  nxt_cnt   = 4'h0;
               end else begin
                  nxt_cnt = 4'(seg_cnt_ff + 4'h1);
               end
            end
            ctb_pkg::SEG_PH1: begin
               if (4'(seg_cnt_ff + 4'h1) >= nxt_ph1) begin
                  nxt_state = ctb_pkg::SEG_PH2;
                  nxt_cnt   = 4'h0;
                  sp_hit    = 1'b1;
               end else begin
                  nxt_cnt = 4'(seg_cnt_ff + 4'h1);
               end
            end
            ctb_pkg::SEG_PH2: begin
               if (4'(seg_cnt_ff + 4'h1) >= nxt_ph2) begin
                  nxt_state = ctb_pkg::SEG_SYNC;
                  nxt_cnt   = 4'h0;
               end else begin
                  nxt_cnt = 4'(seg_cnt_ff + 4'h1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_ff         <= ctb_pkg::SEG_SYNC;
         seg_cnt_ff       <= 4'h0;
         ph1_act_ff       <= 4'h1;
         ph2_act_ff       <= 4'h1;
         resynced_ff      <= 1'b0;
         bit_start_out    <= 1'b0;
         sample_point_out <= 1'b0;
      end else begin
         state_ff         <= nxt_state;
         seg_cnt_ff       <= nxt_cnt;
         ph1_act_ff       <= nxt_ph1;
         ph2_act_ff       <= nxt_ph2;
         resynced_ff      <= nxt_resynced;
         bit_start_out    <= bit_begin;
         sample_point_out <= sp_hit;
      end
   end

   // ---------------- sampling: two preceding quanta plus the sample point
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rx_prev_ff  <= 1'b1;
         hist_ff     <= 2'b11;
         last_bit_ff <= 1'b1;
      end else begin
         rx_prev_ff <= bus_rx_in;
         if (tq_tick) begin
            hist_ff <= {hist_ff[0], bus_rx_in};
         end
         if (sp_hit) begin
            last_bit_ff <= vote_on ? ctb_pkg::ctb_majority({hist_ff, bus_rx_in})
                                   : bus_rx_in;
         end
      end
   end

   // ---------------- wake-up detect; the filter rejects glitches shorter than its span
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         low_run_ff     <= 5'h00;
         wake_event_out <= 1'b0;
      end else begin
         if (bus_rx_in) begin
            low_run_ff <= 5'h00;
         end else if (low_run_ff != ctb_pkg::WAKE_FILT_CYC) begin
            low_run_ff <= 5'(low_run_ff + 5'h01);
         end
         wake_event_out <= wake_sel ?
            (!bus_rx_in && low_run_ff == 5'(ctb_pkg::WAKE_FILT_CYC - 5'h01)) : fall;
      end
   end

   // helper: configuration written since the current bit began
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cfg_dirty_ff <= 1'b1;
      end else if (wr_ack) begin
         cfg_dirty_ff <= 1'b1;
      end else if (bit_begin) begin
         cfg_dirty_ff <= 1'b0;
      end
   end

   sync_quantum_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_ff == ctb_pkg::SEG_SYNC && tq_tick) |=> (state_ff == ctb_pkg::SEG_PROP && bit_start_out))
      else $error("sync quantum not followed by propagation");
   sample_place_a: assert property (@(posedge clk_in) disable iff (reset_in)
      sample_point_out |-> (state_ff == ctb_pkg::SEG_PH2 && seg_cnt_ff == 4'h0
                            && $past(state_ff) == ctb_pkg::SEG_PH1))
      else $error("sample point not at end of phase one");
   prop_length_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_ff == ctb_pkg::SEG_PROP && !cfg_dirty_ff) |-> seg_cnt_ff < prop_len)
      else $error("propagation segment too long");
   ph1_length_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_ff == ctb_pkg::SEG_PH1 && !cfg_dirty_ff && !resynced_ff)
      |-> (seg_cnt_ff < ph1_len && ph1_act_ff == ph1_len))
      else $error("phase one length wrong");
   ph2_length_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_ff == ctb_pkg::SEG_PH2 && !cfg_dirty_ff && !resynced_ff)
      |-> (seg_cnt_ff < ph2_eff && ph2_act_ff == ph2_eff))
      else $error("phase two length wrong");
   ph2_policy_a: assert property (@(posedge clk_in) disable iff (reset_in)
      !seg_reg_ff[ctb_pkg::POLICY_BIT] |-> (ph2_eff >= ctb_pkg::IPT_TQ && ph2_eff >= ph1_len))
      else $error("phase two below phase one or processing time");
   jump_bound_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_ff == ctb_pkg::SEG_PH1 && !cfg_dirty_ff)
      |-> 5'(ph1_act_ff) <= 5'({1'b0, ph1_len} + {1'b0, sjw_len}))
      else $error("resync extension exceeds jump width");
   triple_vote_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (sp_hit && vote_on && hist_ff == 2'b00) |=> !last_bit_ff)
      else $error("majority vote ignored");
   single_sample_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (sp_hit && !vote_on) |=> last_bit_ff == $past(bus_rx_in))
      else $error("single sample not taken");
   wake_filter_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (wake_event_out && $past(wake_sel)) |-> low_run_ff == ctb_pkg::WAKE_FILT_CYC)
      else $error("wake without filtered low run");
   bus_answer_a: assert property (@(posedge clk_in) disable iff (reset_in)
      ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer not one cycle");

   vote_cov_c:   cover property (@(posedge clk_in) disable iff (reset_in) sp_hit && vote_on);
   extend_cov_c: cover property (@(posedge clk_in) disable iff (reset_in)
      resync_ok && state_ff == ctb_pkg::SEG_PH1);
   early_cov_c:  cover property (@(posedge clk_in) disable iff (reset_in) early_end);
   wake_cov_c:   cover property (@(posedge clk_in) disable iff (reset_in) wake_event_out && wake_sel);
endmodule : ctb_bit_timing

// ---- ctb_bus_node.sv ----
// far-side bus node model: holds the line dominant for a commanded number of clocks
`timescale 1ns/10ps
module ctb_bus_node (
   input  wire logic       clk_in,     // module clock
   input  wire logic       start_in,   // begin a dominant stretch
   input  wire logic [7:0] len_in,     // stretch length in clocks
   output logic            bus_rx_out  // bus line, 1 = recessive
);
   logic [7:0] left_ff;

   // starts idle; no reset pin, so the unknown start value is cleared by the first if
   always @(posedge clk_in) begin
      if (left_ff === 8'hXX) begin
         left_ff <= 8'h00;
      end
      if (start_in) begin
         left_ff <= len_in;
      end else if (left_ff != 8'h00 && left_ff !== 8'hXX) begin
         left_ff <= left_ff - 8'h01;
      end
   end

   // released line rests recessive, as the bus termination pulls it there
   assign bus_rx_out = (left_ff === 8'hXX) || (left_ff == 8'h00);
endmodule : ctb_bus_node

// ---- ctb_pkg.sv ----
// constants, types and helpers for the bit-timing configuration block
// What this block does
// - Resync jump width is two-bit code plus one quanta, one to four.
// - Time quantum lasts two times prescaler-plus-one module clock periods.
// - Wake filter select set: wake detect through line filter, else raw edge.
// - Phase two length is three-bit code plus one quanta, one to eight.
// - Policy bit set: programmed phase two; clear: larger of phase one, IPT.
// - Phase one length is three-bit code plus one quanta, up to eight.
// - Propagation length is three-bit code plus one quanta, one to eight.
package ctb_pkg;
   localparam logic [3:0]  OFS_PRESCALE_JUMP = 4'h0;
   localparam logic [3:0]  OFS_SEGMENTS      = 4'h4;
   localparam logic [3:0]  OFS_STATUS        = 4'h8;
   localparam logic [15:0] RST_PRESCALE_JUMP = 16'h0000;
   localparam logic [15:0] RST_SEGMENTS      = 16'h0000;
   localparam logic [15:0] MASK_PRESCALE_JUMP = 16'h00FF;
   localparam logic [15:0] MASK_SEGMENTS      = 16'h47FF;
   localparam int JUMP_LSB      = 6;
   localparam int PRESCALE_LSB  = 0;
   localparam int WAKE_BIT      = 14;
   localparam int PH2_LSB       = 8;
   localparam int POLICY_BIT    = 7;
   localparam int VOTE_BIT      = 6;
   localparam int PH1_LSB       = 3;
   localparam int PROP_LSB      = 0;
   localparam int ST_BIT        = 0;
   localparam int ST_SEG_LSB    = 1;
   localparam int ST_RESYNC     = 3;
   // information processing time in quanta
   localparam logic [3:0]  IPT_TQ = 4'h2;
   localparam int CLK_PERIOD_NS = 5;
   localparam int WAKE_FILT_NS  = 100;
   localparam logic [4:0]  WAKE_FILT_CYC =
      5'((WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} ctb_seg_e;
   function automatic logic [3:0] ctb_len(input logic [2:0] code);
      ctb_len = {1'b0, code} + 4'h1;
   endfunction : ctb_len
   function automatic logic [15:0] ctb_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
      ctb_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : ctb_merge
   function automatic logic ctb_majority(input logic [2:0] s);
      ctb_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : ctb_majority
endpackage : ctb_pkg

// ---- ctb_quantum_div.sv ----
// time quantum divider: one-cycle tick every 2*(prescale+1) clocks
`timescale 1ns/10ps
module ctb_quantum_div (
   input  wire logic       clk_in,      // module clock
   input  wire logic       reset_in,    // async reset, high
   input  wire logic [5:0] prescale_in, // prescaler field
   output logic            tick_out     // quantum tick
);
   logic [6:0] cnt_ff;
   logic [6:0] terminal;
   logic [7:0] gap_ff;
   logic [5:0] pre_last_ff;
   logic       steady_ff;

   assign terminal = {prescale_in, 1'b1};

   // compare with >= so a smaller prescale written mid-count cannot overrun
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_ff   <= 7'h00;
         tick_out <= 1'b0;
      end else if (cnt_ff >= terminal) begin
         cnt_ff   <= 7'h00;
         tick_out <= 1'b1;
      end else begin
         cnt_ff   <= 7'(cnt_ff + 7'h01);
         tick_out <= 1'b0;
      end
   end

   // helper: clocks since the previous tick
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         gap_ff <= 8'h00;
      end else if (tick_out) begin
         gap_ff <= 8'h01;
      end else if (gap_ff != 8'hFF) begin
         gap_ff <= 8'(gap_ff + 8'h01);
      end
   end

   // helper: prescale unchanged over the whole interval, else the spacing is mixed
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pre_last_ff <= 6'h00;
         steady_ff   <= 1'b1;
      end else begin
         pre_last_ff <= prescale_in;
         if (tick_out) begin
            steady_ff <= 1'b1;
         end else if (prescale_in != pre_last_ff) begin
            steady_ff <= 1'b0;
         end
      end
   end

   tq_spacing_a: assert property (@(posedge clk_in) disable iff (reset_in)
      (tick_out && gap_ff != 8'h00 && steady_ff && $past(tick_out) == 1'b0)
      |-> (gap_ff == 8'({1'b0, prescale_in} + 7'h01) * 8'h02))
      else $error("quantum spacing wrong");
endmodule : ctb_quantum_div

// ---- tb_can_bit_timing_config.sv ----
// self-checking bench for the bit-timing configuration block
`timescale 1ns/10ps
module tb_can_bit_timing_config;
   logic        clk_in, reset_in, avs_read_in, avs_write_in, node_start;
   logic        avs_waitrequest_out, bus_rx_in, tq_tick_out, bit_start_out;
   logic        sample_point_out, sampled_bit_out, wake_event_out;
   logic [1:0]  segment_out;
   logic [3:0]  avs_address_in, avs_byteenable_in;
   logic [7:0]  node_len;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [15:0] exp_rd[$];
   int          exp_bit[$];
   int          exp_tq[$];
   int          mismatches, compares, cyc, last_bit, last_tq, wakes, samples;

   ctb_bit_timing uut (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .bus_rx_in(bus_rx_in), .tq_tick_out(tq_tick_out), .bit_start_out(bit_start_out),
      .sample_point_out(sample_point_out), .sampled_bit_out(sampled_bit_out),
      .segment_out(segment_out), .wake_event_out(wake_event_out));

   ctb_bus_node far_node (.clk_in(clk_in), .start_in(node_start), .len_in(node_len),
      .bus_rx_out(bus_rx_in));

   initial clk_in = 1'b0;
   always #2.5 clk_in = ~clk_in;

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk

   task automatic stop_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // results are judged here, against notes left by the driver
   always @(posedge clk_in) begin
      cyc++;
      if (avs_read_in && avs_waitrequest_out === 1'b0 && exp_rd.size() > 0) begin
         chk("readdata", {16'h0000, exp_rd.pop_front()}, avs_readdata_out);
      end
      if (bit_start_out === 1'b1) begin
         if (exp_bit.size() > 0) begin
            chk("bit_clocks", exp_bit.pop_front(), cyc - last_bit);
            chk("samples_per_bit", 1, samples);
         end
         chk("segment_at_start", {30'h0, 2'(ctb_pkg::SEG_PROP)}, {30'h0, segment_out});
         last_bit = cyc;
         samples = 0;
      end
      if (tq_tick_out === 1'b1) begin
         if (exp_tq.size() > 0) begin
            chk("tq_clocks", exp_tq.pop_front(), cyc - last_tq);
         end
         last_tq = cyc;
      end
      if (sample_point_out === 1'b1) begin
         samples++;
         chk("segment_at_sample", {30'h0, 2'(ctb_pkg::SEG_PH2)}, {30'h0, segment_out});
      end
      if (wake_event_out === 1'b1) wakes++;
   end

   // one avalon access; holds everything until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         $display("[ERR] waitrequest expected 0 seen %0h", avs_waitrequest_out);
      end
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
   endtask : rd

   task automatic wait_bits(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 20000) begin
         @(posedge clk_in);
         k++;
         if (bit_start_out === 1'b1) n--;
      end
      if (n > 0) begin
         mismatches++;
         $display("[ERR] bit_starts expected 0 seen %0d", n);
      end
      #1;
   endtask : wait_bits

   task automatic low_pulse(input logic [7:0] n);
      @(posedge clk_in);
      node_start <= 1'b1;
      node_len <= n;
      @(posedge clk_in);
      node_start <= 1'b0;
   endtask : low_pulse

   initial begin
      #400us;
      mismatches++;
      stop_test();
   end

   initial begin
      logic [5:0]  pre;
      logic [2:0]  p, a, b;
      logic [1:0]  jw;
      logic [15:0] w0, w1;
      int          nb, nq;
      {mismatches, compares, cyc, last_bit, last_tq, wakes, samples} = '0;
      {avs_read_in, avs_write_in, node_start} = '0;
      avs_address_in = 4'h0;
      avs_byteenable_in = 4'h0;
      avs_writedata_in = 32'h0000_0000;
      node_len = 8'h00;
      reset_in = 1'b1;
      void'($urandom(69));
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(ctb_pkg::OFS_PRESCALE_JUMP, ctb_pkg::RST_PRESCALE_JUMP);
      rd(ctb_pkg::OFS_SEGMENTS, ctb_pkg::RST_SEGMENTS);
      bus(1'b1, ctb_pkg::OFS_PRESCALE_JUMP, 32'hFFFF_FFFF, 4'hF);
      bus(1'b1, ctb_pkg::OFS_SEGMENTS, 32'hFFFF_FFFF, 4'hF);
      rd(ctb_pkg::OFS_PRESCALE_JUMP, ctb_pkg::MASK_PRESCALE_JUMP);
      rd(ctb_pkg::OFS_SEGMENTS, ctb_pkg::MASK_SEGMENTS);
      // upper lane only: lower byte must survive
      bus(1'b1, ctb_pkg::OFS_SEGMENTS, 32'h0000_0000, 4'h2);
      rd(ctb_pkg::OFS_SEGMENTS, ctb_pkg::MASK_SEGMENTS & 16'h00FF);
      bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
      rd(4'hC, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         pre = (i == 7) ? 6'h3F : 6'($urandom_range(3));
         jw = 2'($urandom);
         p = 3'($urandom);
         a = 3'($urandom);
         b = 3'($urandom);
         w0 = {8'h00, jw, pre};
         w1 = {1'b0, 1'b0, 3'b000, b, i[0], i[1], a, p};
         bus(1'b1, ctb_pkg::OFS_PRESCALE_JUMP, {16'($urandom), w0}, 4'hF);
         bus(1'b1, ctb_pkg::OFS_SEGMENTS, {16'($urandom), w1}, 4'hF);
         rd(ctb_pkg::OFS_PRESCALE_JUMP, w0);
         rd(ctb_pkg::OFS_SEGMENTS, w1);
         nb = i[0] ? int'(b) + 1 : ((int'(a) + 1 > int'(ctb_pkg::IPT_TQ)) ?
              int'(a) + 1 : int'(ctb_pkg::IPT_TQ));
         nq = 1 + int'(p) + 1 + int'(a) + 1 + nb;
         wait_bits(2);
         repeat (3) exp_bit.push_back(nq * 2 * (int'(pre) + 1));
         repeat (3) exp_tq.push_back(2 * (int'(pre) + 1));
         wait_bits(4);
      end
      bus(1'b1, ctb_pkg::OFS_PRESCALE_JUMP, 32'h0000_0000, 4'hF);
      for (int w = 0; w < 2; w++) begin
         bus(1'b1, ctb_pkg::OFS_SEGMENTS, {17'h0, w[0], 7'h00, w[0], 6'h00}, 4'hF);
         repeat (20) @(posedge clk_in);
         wakes = 0;
         low_pulse(8'h05);
         repeat (60) @(posedge clk_in);
         chk("wake_short", w[0] ? 32'h0 : 32'h1, wakes);
         wakes = 0;
         low_pulse(8'd200);
         repeat (100) @(posedge clk_in);
         chk("sampled_low", 32'h0, {31'h0, sampled_bit_out});
         repeat (200) @(posedge clk_in);
         chk("sampled_high", 32'h1, {31'h0, sampled_bit_out});
         chk("wake_long", 32'h1, wakes);
      end
      chk("pending_notes", 32'h0, 32'(exp_rd.size() + exp_bit.size() + exp_tq.size()));
      stop_test();
   end
endmodule : tb_can_bit_timing_config
